// ===== hdl/dcd_dma.v
// Purpose: two-channel dma unit with apb registers and system bus master
// Assumes: one clock pclk at 50 MHz, presetn asynchronous active low
// Notes:   system bus inputs share pclk; drq and nmi pins are synchronised
//
// Summary of operation
// - bit 15 picks destination memory or io
// - bits 14:13 step destination address
// - bit 12 picks source memory or io
// - bits 11:10 step source address
// - bit 9 stops channel at terminal count
// - bit 8 raises interrupt on last transfer
// - bits 7:6 choose request synchronisation mode
// - bit 5 sets priority between channels
// - bit 4 accepts timer requests
// - bit 0 selects byte or word transfer
// - dma beats cpu except odd-word or locked
// - cpu memory blocked during dma transfer
// - maskable interrupts never suspend a transfer
// - nmi blocks new transfers, one in progress completes
// - serial port may pace either channel
// - fetch then deposit, eight clocks minimum
// - twenty-bit source and destination addresses
// - sixteen-bit count, ends when exhausted
// - register writes take effect immediately
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_consts.vh"

module dcd_dma (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire drq0_pin,
  input wire drq1_pin,
  input wire nmi_pin,
  input wire timer_tick,
  input wire serial_rx_req,
  input wire serial_tx_req,
  input wire cpu_lock,
  input wire cpu_odd_word,
  input wire sys_ready,
  input wire [15:0] sys_rdata,
  output reg cpu_block,
  output reg bus_cyc,
  output reg [19:0] bus_addr,
  output reg bus_io,
  output reg bus_wr,
  output reg bus_word,
  output reg [15:0] bus_wdata,
  output reg dma_irq0,
  output reg dma_irq1
);

  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_FETCH = 3'h2;
  localparam [2:0] S_DEPOSIT = 3'h4;

  reg [2:0] state_r;
  reg [1:0] tst_r;
  reg chan_r;
  reg [15:0] data_r;
  reg [1:0] timer_pend_r;
  reg [1:0] done_r;
  wire [2:0] pin_sync;
  wire [1:0] drq_s;
  wire nmi_s;
  wire [15:0] ctrl0, ctrl1;
  wire [19:0] src0, src1, dst0, dst1;
  wire [15:0] cnt0, cnt1;
  wire [15:0] cur_ctrl;
  wire [19:0] cur_src, cur_dst;
  wire [15:0] cur_cnt;
  wire [1:0] req;
  wire pick;
  wire start;
  wire [7:0] idx;
  wire aligned;
  wire apb_wr;
  wire [1:0] ch_wr;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  dcd_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({nmi_pin, drq1_pin, drq0_pin}),
    .sync_out(pin_sync)
  );
  assign drq_s = pin_sync[1:0];
  assign nmi_s = pin_sync[2];

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  // write acts on the access-phase edge that sees pready
  assign apb_wr = psel && penable && pready && pwrite && aligned;
  assign ch_wr[0] = apb_wr && (idx[7:4] == `DCD_IDX_CH0_BASE >> 4);
  assign ch_wr[1] = apb_wr && (idx[7:4] == `DCD_IDX_CH1_BASE >> 4);

  dcd_channel u_ch0 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ch_wr[0]),
    .wr_sub(idx[3:0]),
    .wdata(pwdata[15:0]),
    .xfer_done(done_r[0]),
    .ctrl(ctrl0),
    .src_addr(src0),
    .dst_addr(dst0),
    .count(cnt0)
  );

  dcd_channel u_ch1 (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(ch_wr[1]),
    .wr_sub(idx[3:0]),
    .wdata(pwdata[15:0]),
    .xfer_done(done_r[1]),
    .ctrl(ctrl1),
    .src_addr(src1),
    .dst_addr(dst1),
    .count(cnt1)
  );

  // channel-register read value, shared by both channels
  function [15:0] ch_read;
    input [3:0] sub;
    input [15:0] c;
    input [19:0] s;
    input [19:0] d;
    input [15:0] n;
    begin
      case (sub)
        `DCD_SUB_DST_LO: ch_read = d[15:0];
        `DCD_SUB_DST_HI: ch_read = {12'h000, d[19:16]};
        `DCD_SUB_SRC_LO: ch_read = s[15:0];
        `DCD_SUB_SRC_HI: ch_read = {12'h000, s[19:16]};
        `DCD_SUB_COUNT: ch_read = n;
        `DCD_SUB_CTRL: ch_read = c;
        default: ch_read = 16'h0000;
      endcase
    end
  endfunction

  // valid decode for a word index
  function idx_ok;
    input [7:0] i;
    begin
      idx_ok = ((i[7:4] == (`DCD_IDX_CH0_BASE >> 4)) ||
                (i[7:4] == (`DCD_IDX_CH1_BASE >> 4))) &&
               (i[0] == 1'b0) && (i[3:0] <= `DCD_SUB_CTRL);
      if (i == `DCD_IDX_STATUS)
        idx_ok = 1'b1;
    end
  endfunction

  // one wait state, then answer; unmapped or misaligned gives pslverr
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !(aligned && idx_ok(idx)) || (pwrite && idx == `DCD_IDX_STATUS);
      if (!pwrite && aligned && idx_ok(idx)) begin
        if (idx == `DCD_IDX_STATUS)
          prdata <= {26'h0000000, nmi_s, state_r != S_IDLE, chan_r,
                     cpu_block, ctrl1[`DCD_C_ARM], ctrl0[`DCD_C_ARM]};
        else if (idx[7:4] == (`DCD_IDX_CH0_BASE >> 4))
          prdata <= {16'h0000, ch_read(idx[3:0], ctrl0, src0, dst0, cnt0)};
        else
          prdata <= {16'h0000, ch_read(idx[3:0], ctrl1, src1, dst1, cnt1)};
      end else
        prdata <= 32'h00000000;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request generation
  // ----------------------------------------------------------------
  // request of one channel from its control and pacing inputs
  function ch_req;
    input [15:0] c;
    input drq;
    input tpend;
    reg paced;
    begin
      if (c[`DCD_C_SERIAL])
        paced = (c[`DCD_C_SYNC_HI:`DCD_C_SYNC_LO] == `DCD_SYNC_DST) ?
                serial_tx_req : serial_rx_req;
      else
        paced = drq;
      case (c[`DCD_C_SYNC_HI:`DCD_C_SYNC_LO])
        `DCD_SYNC_SRC: ch_req = paced;
        `DCD_SYNC_DST: ch_req = paced;
        default: ch_req = 1'b1;
      endcase
      if (c[`DCD_C_TIMER_EN])
        ch_req = tpend;
      ch_req = ch_req && c[`DCD_C_ARM];
    end
  endfunction

  assign req[0] = ch_req(ctrl0, drq_s[0], timer_pend_r[0]);
  assign req[1] = ch_req(ctrl1, drq_s[1], timer_pend_r[1]);

  // priority: high-priority channel wins a tie; equal goes to channel 0
  assign pick = req[1] && (!req[0] || (ctrl1[`DCD_C_PRIO] && !ctrl0[`DCD_C_PRIO]));

  // start only if cpu not locked or odd-word, and no nmi
  // no maskable interrupt input takes part here
  assign start = (state_r == S_IDLE) && (req != 2'h0) && !nmi_s &&
                 !cpu_lock && !cpu_odd_word && (done_r == 2'h0); // step lands first

  assign cur_ctrl = chan_r ? ctrl1 : ctrl0;
  assign cur_src = chan_r ? src1 : src0;
  assign cur_dst = chan_r ? dst1 : dst0;
  assign cur_cnt = chan_r ? cnt1 : cnt0;

  // timer ticks wait per channel until a transfer consumes them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      timer_pend_r <= 2'h0;
    else begin
      if (timer_tick)
        timer_pend_r <= 2'h3;
      else if (start)
        timer_pend_r[pick] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transfer engine: fetch bus cycle then deposit bus cycle
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      tst_r <= `DCD_T1;
      chan_r <= 1'b0;
      data_r <= 16'h0000;
      done_r <= 2'h0;
      cpu_block <= 1'b0;
      bus_cyc <= 1'b0;
      bus_addr <= 20'h00000;
      bus_io <= 1'b0;
      bus_wr <= 1'b0;
      bus_word <= 1'b0;
      bus_wdata <= 16'h0000;
      dma_irq0 <= 1'b0;
      dma_irq1 <= 1'b0;
    end else begin
      done_r <= 2'h0;
      dma_irq0 <= 1'b0;
      dma_irq1 <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start) begin
            chan_r <= pick;
            state_r <= S_FETCH;
            tst_r <= `DCD_T1;
            // cpu held off memory for the whole transfer
            cpu_block <= 1'b1;
            bus_cyc <= 1'b1;
            bus_wr <= 1'b0;
            bus_addr <= pick ? src1 : src0;
            bus_io <= pick ? ctrl1[`DCD_C_SRC_IO] : ctrl0[`DCD_C_SRC_IO];
            bus_word <= pick ? ctrl1[`DCD_C_WORD] : ctrl0[`DCD_C_WORD];
          end
        end
        S_FETCH: begin
          // four clocks minimum per bus cycle
          case (tst_r)
            `DCD_T3: begin
              if (sys_ready) begin
                tst_r <= `DCD_T4;
                // byte from odd address comes on the high lane
                if (!bus_word && bus_addr[0])
                  data_r <= {sys_rdata[15:8], sys_rdata[15:8]};
                else if (!bus_word)
                  data_r <= {sys_rdata[7:0], sys_rdata[7:0]};
                else
                  data_r <= sys_rdata;
              end
            end
            `DCD_T4: begin
              state_r <= S_DEPOSIT;
              tst_r <= `DCD_T1;
              bus_wr <= 1'b1;
              bus_addr <= cur_dst;
              bus_io <= cur_ctrl[`DCD_C_DST_IO];
              bus_word <= cur_ctrl[`DCD_C_WORD];
              bus_wdata <= data_r;
            end
            default: tst_r <= tst_r + 2'h1;
          endcase
        end
        S_DEPOSIT: begin
          case (tst_r)
            `DCD_T3: begin
              if (sys_ready)
                tst_r <= `DCD_T4;
            end
            `DCD_T4: begin
              state_r <= S_IDLE;
              tst_r <= `DCD_T1;
              bus_cyc <= 1'b0;
              bus_wr <= 1'b0;
              cpu_block <= 1'b0;
              done_r[chan_r] <= 1'b1;
              // interrupt when the count runs out
              if (cur_ctrl[`DCD_C_IRQ_EN] && cur_cnt == 16'h0001) begin
                dma_irq0 <= !chan_r;
                dma_irq1 <= chan_r;
              end
            end
            default: tst_r <= tst_r + 2'h1;
          endcase
        end
        default: begin
          state_r <= S_IDLE;
          bus_cyc <= 1'b0;
          cpu_block <= 1'b0;
        end
      endcase
    end
  end

endmodule // dcd_dma

`default_nettype wire

// ===== hdl/dcd_consts.vh
// Purpose: shared constants of the two-channel dma unit
// Assumes: included by bare name from the top module, the channel module and the bench; the synchroniser does not use it
// Notes:   register indices are word indices, byte address is index times four
`ifndef DCD_CONSTS_VH
`define DCD_CONSTS_VH

// ----------------------------------------------------------------
// register map (word indices)
// ----------------------------------------------------------------
`define DCD_IDX_CH0_BASE 8'hC0
`define DCD_IDX_CH1_BASE 8'hD0
`define DCD_IDX_CH0_CTRL 8'hCA
`define DCD_IDX_CH1_CTRL 8'hDA
`define DCD_IDX_STATUS 8'hF0
`define DCD_SUB_DST_LO 4'h0
`define DCD_SUB_DST_HI 4'h2
`define DCD_SUB_SRC_LO 4'h4
`define DCD_SUB_SRC_HI 4'h6
`define DCD_SUB_COUNT 4'h8
`define DCD_SUB_CTRL 4'hA

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DCD_C_DST_IO 15
`define DCD_C_DST_STEP_HI 14
`define DCD_C_DST_STEP_LO 13
`define DCD_C_SRC_IO 12
`define DCD_C_SRC_STEP_HI 11
`define DCD_C_SRC_STEP_LO 10
`define DCD_C_STOP_TC 9
`define DCD_C_IRQ_EN 8
`define DCD_C_SYNC_HI 7
`define DCD_C_SYNC_LO 6
`define DCD_C_PRIO 5
`define DCD_C_TIMER_EN 4
`define DCD_C_SERIAL 3
`define DCD_C_ARM 1
`define DCD_C_WORD 0
`define DCD_CTRL_WMASK 16'hFFFB
`define DCD_CTRL_RESET 16'h0000

// step and sync encodings
`define DCD_STEP_INC 2'h1
`define DCD_STEP_DEC 2'h2
`define DCD_SYNC_NONE 2'h0
`define DCD_SYNC_SRC 2'h1
`define DCD_SYNC_DST 2'h2

// ----------------------------------------------------------------
// bus cycle timing: four states per bus cycle, two cycles per transfer
// ----------------------------------------------------------------
`define DCD_T1 2'h0
`define DCD_T2 2'h1
`define DCD_T3 2'h2
`define DCD_T4 2'h3
`define DCD_ADDR_W 20
`define DCD_HI_W 4

`endif

// ===== hdl/dcd_sync2.v
// Purpose: two-flop synchroniser for the request and nmi pins
// Assumes: inputs are asynchronous to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module dcd_sync2 (
  input wire pclk,
  input wire presetn,
  input wire [2:0] async_in,
  output wire [2:0] sync_out
);

  reg [2:0] meta_r;
  reg [2:0] sync_r;

  // two stages, reset to inactive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule // dcd_sync2

`default_nettype wire

// ===== hdl/dcd_channel.v
// Purpose: register set and address stepping of one dma channel
// Assumes: writes come from the apb slave in the top module
// Notes:   a software write in the same cycle as a step wins
`timescale 1ns/1ps
`default_nettype none
`include "dcd_consts.vh"

module dcd_channel (
  input wire pclk,
  input wire presetn,
  input wire wr_en,
  input wire [3:0] wr_sub,
  input wire [15:0] wdata,
  input wire xfer_done,
  output wire [15:0] ctrl,
  output wire [19:0] src_addr,
  output wire [19:0] dst_addr,
  output wire [15:0] count
);

  reg [15:0] ctrl_r;
  reg [19:0] src_r;
  reg [19:0] dst_r;
  reg [15:0] cnt_r;
  wire [15:0] cnt_nxt;
  wire stop_now;

  // step an address by one byte or one word, up, down or not at all
  function [19:0] step_addr;
    input [19:0] addr;
    input [1:0] mode;
    input word;
    reg [19:0] amt;
    begin
      amt = word ? 20'h00002 : 20'h00001;
      if (mode == `DCD_STEP_INC)
        step_addr = addr + amt;
      else if (mode == `DCD_STEP_DEC)
        step_addr = addr - amt;
      else
        step_addr = addr;
    end
  endfunction

  assign cnt_nxt = cnt_r - 16'h0001;
  assign stop_now = ctrl_r[`DCD_C_STOP_TC] && (cnt_nxt == 16'h0000);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `DCD_CTRL_RESET;
      src_r <= 20'h00000;
      dst_r <= 20'h00000;
      cnt_r <= 16'h0000;
    end else begin
      if (xfer_done) begin
        dst_r <= step_addr(dst_r, ctrl_r[`DCD_C_DST_STEP_HI:`DCD_C_DST_STEP_LO],
                           ctrl_r[`DCD_C_WORD]);
        src_r <= step_addr(src_r, ctrl_r[`DCD_C_SRC_STEP_HI:`DCD_C_SRC_STEP_LO],
                           ctrl_r[`DCD_C_WORD]);
        cnt_r <= cnt_nxt;
        if (stop_now)
          ctrl_r[`DCD_C_ARM] <= 1'b0;
      end
      if (wr_en) begin
        case (wr_sub)
          `DCD_SUB_DST_LO: dst_r[15:0] <= wdata;
          `DCD_SUB_DST_HI: dst_r[19:16] <= wdata[`DCD_HI_W-1:0];
          `DCD_SUB_SRC_LO: src_r[15:0] <= wdata;
          `DCD_SUB_SRC_HI: src_r[19:16] <= wdata[`DCD_HI_W-1:0];
          `DCD_SUB_COUNT: cnt_r <= wdata;
          `DCD_SUB_CTRL: ctrl_r <= wdata & `DCD_CTRL_WMASK;
          default: ;
        endcase
      end
    end
  end

  assign ctrl = ctrl_r;
  assign src_addr = src_r;
  assign dst_addr = dst_r;
  assign count = cnt_r;

endmodule // dcd_channel

`default_nettype wire

// ===== verification/dcd_dma_properties.sv
// Purpose: concurrent checks on the ports of the two-channel dma unit
// Assumes: single clock pclk, presetn asynchronous active low
// Notes:   attached to every dcd_dma by the bind below
`timescale 1ns/1ps
`default_nettype none

module dcd_dma_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic nmi_pin,
  input wire logic cpu_lock,
  input wire logic cpu_odd_word,
  input wire logic cpu_block,
  input wire logic bus_cyc,
  input wire logic bus_wr,
  input wire logic dma_irq0,
  input wire logic dma_irq1
);
  // ----------------------------------------------------------------
  // register bus answers
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_error_no_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("refused access returned data or no ready");

  // ----------------------------------------------------------------
  // system bus ownership and transfer shape
  // ----------------------------------------------------------------
  a_block_with_xfer: assert property (cpu_block == bus_cyc)
    else $error("cpu block differs from transfer activity");
  a_xfer_min_len: assert property ($rose(bus_cyc) |-> bus_cyc [*8])
    else $error("transfer shorter than eight clocks");
  a_fetch_first: assert property ($rose(bus_cyc) |-> !bus_wr ##[4:400] bus_wr)
    else $error("transfer did not fetch before deposit");
  a_deposit_last: assert property ($fell(bus_cyc) |-> $past(bus_wr))
    else $error("transfer ended without a deposit");
  a_cpu_hold_wait: assert property ($rose(bus_cyc) |-> !$past(cpu_lock) && !$past(cpu_odd_word))
    else $error("transfer started over a locked or odd word cpu cycle");
  a_nmi_stall: assert property (nmi_pin [*6] |-> !$rose(bus_cyc))
    else $error("transfer started while nmi held");
  a_irq_at_end: assert property ((dma_irq0 || dma_irq1) |-> $fell(bus_cyc))
    else $error("interrupt pulse not at end of transfer");
endmodule // dcd_dma_props

bind dcd_dma dcd_dma_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
  .cpu_lock(cpu_lock), .cpu_odd_word(cpu_odd_word), .cpu_block(cpu_block),
  .bus_cyc(bus_cyc), .bus_wr(bus_wr), .dma_irq0(dma_irq0), .dma_irq1(dma_irq1));
`default_nettype wire

// ===== verification/dcd_sysbus_model.sv
// Purpose: memory and io space answering the dma system bus
// Assumes: bus outputs stable per bus cycle, same clock
// Notes:   slow adds wait states; released data shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none

module dcd_sysbus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_cyc,
  input wire logic [19:0] bus_addr,
  input wire logic bus_io,
  input wire logic bus_wr,
  input wire logic bus_word,
  input wire logic [15:0] bus_wdata,
  input wire logic slow,
  output logic sys_ready,
  output logic [15:0] sys_rdata
);
  logic [15:0] mem [0:255];
  logic [1:0] wait_r;
  logic cyc_r, wr_r;
  logic [15:0] last_r;
  wire [7:0] ix = {bus_io, bus_addr[7:1]};

  // wait states restart at each bus cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 2'h0;
      cyc_r <= 1'b0;
      wr_r <= 1'b0;
      last_r <= 16'h0000;
    end else begin
      cyc_r <= bus_cyc;
      wr_r <= bus_wr;
      if (bus_cyc && (!cyc_r || bus_wr != wr_r)) wait_r <= slow ? 2'h3 : 2'h0;
      else if (wait_r != 2'h0) wait_r <= wait_r - 2'h1;
      if (bus_cyc && !bus_wr) last_r <= mem[ix];
      // byte deposits update one lane only
      if (bus_cyc && bus_wr && bus_word) mem[ix] <= bus_wdata;
      else if (bus_cyc && bus_wr && bus_addr[0]) mem[ix][15:8] <= bus_wdata[15:8];
      else if (bus_cyc && bus_wr) mem[ix][7:0] <= bus_wdata[7:0];
    end
  end

  // data only while fetching, otherwise a changed value so stale data never matches
  always @* begin
    sys_ready = bus_cyc && wait_r == 2'h0;
    sys_rdata = (bus_cyc && !bus_wr) ? mem[ix] : ~last_r;
  end
endmodule // dcd_sysbus_model
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the two-channel dma unit
// Assumes: apb master and system bus model on one 50 MHz clock
// Notes:   seed fixed so every run repeats; serial rx pacing tried once
`timescale 1ns/1ps
`default_nettype none
`include "dcd_consts.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic drq0 = 1'b0, nmi = 1'b0, tick = 1'b0, lock = 1'b0, odd = 1'b0, slow = 1'b0, ser = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, sys_ready, cpu_block, bus_cyc, bus_io, bus_wr, bus_word, irq0, irq1;
  wire [15:0] sys_rdata, bus_wdata;
  wire [19:0] bus_addr;
  logic [31:0] rdat;
  logic rerr, cyc_d, wr_d;
  logic [20:0] fq[$];
  logic [21:0] dq[$];
  int num_errors = 0, check_count = 0, n0 = 0;

  always #10 pclk = ~pclk;

  dcd_dma DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drq0_pin(drq0), .drq1_pin(1'b0), .nmi_pin(nmi), .timer_tick(tick),
    .serial_rx_req(ser), .serial_tx_req(1'b0), .cpu_lock(lock), .cpu_odd_word(odd),
    .sys_ready(sys_ready), .sys_rdata(sys_rdata), .cpu_block(cpu_block), .bus_cyc(bus_cyc),
    .bus_addr(bus_addr), .bus_io(bus_io), .bus_wr(bus_wr), .bus_word(bus_word),
    .bus_wdata(bus_wdata), .dma_irq0(irq0), .dma_irq1(irq1));

  dcd_sysbus_model u_mem (.pclk(pclk), .presetn(presetn), .bus_cyc(bus_cyc),
    .bus_addr(bus_addr), .bus_io(bus_io), .bus_wr(bus_wr), .bus_word(bus_word),
    .bus_wdata(bus_wdata), .slow(slow), .sys_ready(sys_ready), .sys_rdata(sys_rdata));

  // bus monitor: fetch and deposit starts, channel 0 interrupt pulses
  always @(posedge pclk) begin
    cyc_d <= bus_cyc;
    wr_d <= bus_wr;
    if (bus_cyc && !cyc_d) fq.push_back({bus_io, bus_addr});
    if (bus_wr && !wr_d) dq.push_back({bus_word, bus_io, bus_addr});
    if (irq0) n0 <= n0 + 1;
  end

  // ----------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [7:0] ix, input logic [15:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task prog(input logic ch, input logic [19:0] s, input logic [19:0] d,
            input logic [15:0] c, input logic [15:0] cr);
    logic [7:0] b;
    b = ch ? `DCD_IDX_CH1_BASE : `DCD_IDX_CH0_BASE;
    apb(1'b1, b + `DCD_SUB_DST_LO, d[15:0]);
    apb(1'b1, b + `DCD_SUB_DST_HI, {12'h000, d[19:16]});
    apb(1'b1, b + `DCD_SUB_SRC_LO, s[15:0]);
    apb(1'b1, b + `DCD_SUB_SRC_HI, {12'h000, s[19:16]});
    apb(1'b1, b + `DCD_SUB_COUNT, c);
    apb(1'b1, b + `DCD_SUB_CTRL, cr);
  endtask

  // wait until n deposits were seen and the bus is idle again
  task wait_dq(input int n);
    while (dq.size() < n || bus_cyc !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [19:0] stp(input logic [19:0] a, input logic [1:0] m, input logic w);
    if (m == `DCD_STEP_INC) return a + (w ? 20'h00002 : 20'h00001);
    if (m == `DCD_STEP_DEC) return a - (w ? 20'h00002 : 20'h00001);
    return a;
  endfunction

  // armed control word with stop at terminal count always set
  function automatic logic [15:0] ctl(input logic dio, input logic [1:0] ds, input logic sio,
    input logic [1:0] ss, input logic irq, input logic [1:0] sy, input logic pr, input logic tm,
    input logic w);
    return {dio, ds, sio, ss, 1'b1, irq, sy, pr, tm, 2'b00, 1'b1, w};
  endfunction

  task final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog: the whole sequence needs far fewer cycles than this
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [19:0] se[2], de[2], s2;
    logic [15:0] ev[2], w, cr;
    logic [1:0] ss, ds;
    logic wd;
    int b0;
    void'($urandom(77));
    for (int i = 0; i < 256; i++) u_mem.mem[i] = 16'($urandom);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, readback masks and refused accesses, both channels alike
    for (int ch = 0; ch < 2; ch++) begin
      cr = ch ? `DCD_IDX_CH1_BASE : `DCD_IDX_CH0_BASE;
      w = 16'($urandom) & 16'hFFED;
      apb(1'b0, cr + `DCD_SUB_CTRL, 16'h0000);
      `CHK(rdat, 32'h00000000)
      apb(1'b1, cr + `DCD_SUB_CTRL, w);
      apb(1'b0, cr + `DCD_SUB_CTRL, 16'h0000);
      `CHK(rdat, {16'h0000, w & `DCD_CTRL_WMASK})
      apb(1'b1, cr + `DCD_SUB_CTRL, 16'h0000);
      apb(1'b1, cr + `DCD_SUB_SRC_HI, 16'hFFFF);
      apb(1'b0, cr + `DCD_SUB_SRC_HI, 16'h0000);
      `CHK(rdat[15:0], 16'h000F)
      apb(1'b1, cr + `DCD_SUB_COUNT, w);
      apb(1'b0, cr + `DCD_SUB_COUNT, 16'h0000);
      `CHK(rdat[15:0], w)
    end
    apb(1'b0, 8'h10, 16'h0000);
    `CHK({rerr, rdat}, 33'h100000000)
    apb(1'b1, `DCD_IDX_STATUS, 16'hFFFF);
    `CHK(rerr, 1'b1)
    // two-transfer runs over every source step mode, destination up and down, space and size
    for (int k = 0; k < 4; k++) begin
      ss = (k == 1) ? `DCD_STEP_DEC : (k == 2) ? 2'h0 : `DCD_STEP_INC;
      ds = (k == 2) ? `DCD_STEP_DEC : `DCD_STEP_INC;
      wd = (k != 3);
      slow <= 1'($urandom);
      se[0] = 20'h00040;
      se[1] = stp(se[0], ss, wd);
      s2 = stp(se[1], ss, wd);
      de[0] = 20'h00080;
      de[1] = stp(de[0], ds, wd);
      for (int j = 0; j < 2; j++) ev[j] = u_mem.mem[{k[1], se[j][7:1]}];
      fq.delete();
      dq.delete();
      b0 = n0;
      prog(1'b0, se[0], de[0], 16'h0002,
           ctl(k[0], ds, k[1], ss, k != 3, `DCD_SYNC_NONE, 1'b0, 1'b0, wd));
      wait_dq(2);
      for (int j = 0; j < 2; j++) begin
        `CHK(fq[j], {k[1], se[j]})
        `CHK(dq[j], {wd, k[0], de[j]})
        if (wd) `CHK(u_mem.mem[{k[0], de[j][7:1]}], ev[j])
      end
      `CHK(n0 - b0, (k != 3) ? 1 : 0)
      apb(1'b0, `DCD_IDX_CH0_BASE + `DCD_SUB_COUNT, 16'h0000);
      `CHK(rdat[15:0], 16'h0000)
      apb(1'b0, `DCD_IDX_CH0_BASE + `DCD_SUB_SRC_LO, 16'h0000);
      `CHK(rdat[15:0], s2[15:0])
    end
    // cpu lock, odd word and nmi hold both armed channels, then priority decides
    lock <= 1'b1;
    fq.delete();
    dq.delete();
    prog(1'b0, 20'h00010, 20'h00090, 16'h0001,
         ctl(1'b0, `DCD_STEP_INC, 1'b0, `DCD_STEP_INC, 1'b1, `DCD_SYNC_NONE, 1'b0, 1'b0, 1'b1));
    prog(1'b1, 20'h00020, 20'h000A0, 16'h0001,
         ctl(1'b0, `DCD_STEP_INC, 1'b0, `DCD_STEP_INC, 1'b1, `DCD_SYNC_NONE, 1'b1, 1'b0, 1'b1));
    repeat (10) @(posedge pclk);
    odd <= 1'b1;
    lock <= 1'b0;
    repeat (10) @(posedge pclk);
    nmi <= 1'b1;
    repeat (5) @(posedge pclk);
    odd <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK(fq.size(), 0)
    nmi <= 1'b0;
    wait_dq(2);
    `CHK(fq[0], {1'b0, 20'h00020})
    `CHK(fq[1], {1'b0, 20'h00010})
    // request pin pacing on channel 0, timer pacing on channel 1
    fq.delete();
    dq.delete();
    prog(1'b0, 20'h00030, 20'h000B0, 16'h0001,
         ctl(1'b0, `DCD_STEP_INC, 1'b0, `DCD_STEP_INC, 1'b1, `DCD_SYNC_SRC, 1'b0, 1'b0, 1'b1));
    prog(1'b1, 20'h00034, 20'h000B4, 16'h0001,
         ctl(1'b0, `DCD_STEP_INC, 1'b0, `DCD_STEP_INC, 1'b1, `DCD_SYNC_NONE, 1'b0, 1'b1, 1'b1));
    repeat (20) @(posedge pclk);
    `CHK(fq.size(), 0)
    drq0 <= 1'b1;
    wait_dq(1);
    drq0 <= 1'b0;
    `CHK(fq.size(), 1)
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    wait_dq(2);
    `CHK(fq[1], {1'b0, 20'h00034})
    // serial rx pacing on channel 0
    ser <= 1'b1;
    prog(1'b0, 20'h00038, 20'h000B8, 16'h0001, 16'h024B);
    wait_dq(3);
    `CHK(fq[2], {1'b0, 20'h00038})
    final_report();
  end
endmodule // tb
`default_nettype wire
